// ===== verilog/eel_cfg.svh
// Purpose: Constants for the serial EEPROM setup loader
// Assumes: 100 MHz system clock
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef EEL_CFG_SVH
`define EEL_CFG_SVH

// ****************************************************************
// Control bits and host register indices
// ****************************************************************
`define EEL_CTRL_STORE   0
`define EEL_CTRL_RELOAD  1
`define EEL_CTRL_SEL     2
`define EEL_IDX_CFG      3'h0
`define EEL_IDX_BASE     3'h1
`define EEL_IDX_IA01     3'h2
`define EEL_IDX_IA23     3'h3
`define EEL_IDX_IA45     3'h4
`define EEL_IDX_GP       3'h5
`define EEL_IDX_PTR      3'h6

// ****************************************************************
// EEPROM map, defaults and commands
// ****************************************************************
`define EEL_STRAP_FIXED  3'h7
`define EEL_IA_BASE      6'h20
`define EEL_CFG_DEFAULT  16'h0000
`define EEL_BASE_DEFAULT 16'h0000
`define EEL_IA_DEFAULT   16'h0000
`define EEL_OPC_READ     2'h2
`define EEL_OPC_WRITE    2'h1
`define EEL_OPC_EWEN     2'h0
`define EEL_EWEN_ADDR    6'h30
`define EEL_FRAME_LONG   5'h19
`define EEL_FRAME_SHORT  5'h09

// ****************************************************************
// Serial clock timing
// ****************************************************************
`define EEL_CLK_NS       10
`define EEL_SK_HALF_NS   500
`define EEL_SK_HALF_CYC  ((`EEL_SK_HALF_NS + `EEL_CLK_NS - 1) / `EEL_CLK_NS)

`endif

// ===== verilog/eel_pkg.sv
// Purpose: Types for the serial EEPROM setup loader
// Assumes: Nothing beyond the cfg header
// Notes:   Constants live in eel_cfg.svh
package eel_pkg;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_EWEN} eel_op_t;
  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_GAP, S_WAIT} eel_ser_st_t;
  typedef enum logic [1:0] {M_STRAP, M_IDLE, M_ISSUE, M_WAIT} eel_main_st_t;
  typedef enum logic [1:0] {J_LOAD, J_STORE, J_GPRD, J_GPWR} eel_job_t;
endpackage

// ===== verilog/eel_serial.sv
// Purpose: Three-wire serial EEPROM word shifter
// Assumes: EEPROM data-out synchronous to CLK_I
// Notes:   Write waits for the ready level before done
`include "eel_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module eel_serial #(
  parameter int HALF_CYC = `EEL_SK_HALF_CYC
) (
  input  wire logic           clk_i,   // System clock
  input  wire logic           rst_i,   // Sync reset, high
  input  wire logic           start_i, // Start one command
  input  wire eel_pkg::eel_op_t op_i,  // Command kind
  input  wire logic [5:0]     addr_i,  // Word address
  input  wire logic [15:0]    wdata_i, // Write data
  output logic                done_o,  // Command finished pulse
  output logic [15:0]         rdata_o, // Read data
  output logic                cs_o,    // Chip select
  output logic                sk_o,    // Serial clock
  output logic                di_o,    // Data into EEPROM
  input  wire logic           do_i     // Data out of EEPROM
);
  eel_pkg::eel_ser_st_t st_r;
  eel_pkg::eel_op_t     op_r;
  logic [15:0]          div_r;
  logic [24:0]          sh_r;
  logic [4:0]           cnt_r;
  logic                 tick;
  logic                 sk_hi_r;

  // Start bit, opcode, 6-bit word address, then data
  function automatic logic [24:0] frame(input eel_pkg::eel_op_t op,
                                        input logic [5:0] a,
                                        input logic [15:0] d);
    if (op == eel_pkg::OP_READ) begin
      frame = {1'b1, `EEL_OPC_READ, a, 16'h0000};
    end else if (op == eel_pkg::OP_WRITE) begin
      frame = {1'b1, `EEL_OPC_WRITE, a, d};
    end else begin
      frame = {1'b1, `EEL_OPC_EWEN, `EEL_EWEN_ADDR, 16'h0000};
    end
  endfunction

  assign tick  = (div_r == 16'(HALF_CYC - 1));
  assign di_o  = sh_r[24];
  assign sk_o  = st_r == eel_pkg::S_SHIFT ? sk_hi_r : 1'b0;

  // Half-period divider, idle outside commands
  always_ff @(posedge clk_i) begin
    if (rst_i || st_r == eel_pkg::S_IDLE || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  // Data is sampled on falling SK; the last 16 samples are the word
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      st_r    <= eel_pkg::S_IDLE;
      op_r    <= eel_pkg::OP_READ;
      sh_r    <= 25'h0;
      cnt_r   <= 5'h0;
      cs_o    <= 1'b0;
      sk_hi_r <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      case (st_r)
        eel_pkg::S_IDLE: begin
          if (start_i) begin
            op_r  <= op_i;
            sh_r  <= frame(op_i, addr_i, wdata_i);
            cnt_r <= op_i == eel_pkg::OP_EWEN ? `EEL_FRAME_SHORT : `EEL_FRAME_LONG;
            cs_o  <= 1'b1;
            st_r  <= eel_pkg::S_SHIFT;
          end
        end
        eel_pkg::S_SHIFT: begin
          if (tick && !sk_hi_r) begin
            sk_hi_r <= 1'b1;
          end else if (tick) begin
            sk_hi_r <= 1'b0;
            sh_r    <= {sh_r[23:0], 1'b0};
            rdata_o <= {rdata_o[14:0], do_i};
            cnt_r   <= cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
              cs_o <= 1'b0;
              st_r <= op_r == eel_pkg::OP_WRITE ? eel_pkg::S_GAP : eel_pkg::S_IDLE;
              done_o <= op_r != eel_pkg::OP_WRITE;
            end
          end
        end
        eel_pkg::S_GAP: begin
          if (tick) begin // Reselect to poll the busy level
            cs_o <= 1'b1;
            st_r <= eel_pkg::S_WAIT;
          end
        end
        default: begin
          // Ready level settles a while after reselect; sample on tick only
          if (tick && do_i) begin
            cs_o   <= 1'b0;
            done_o <= 1'b1;
            st_r   <= eel_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  AST_SER_SELECT: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r == eel_pkg::S_IDLE && start_i) |=> cs_o && di_o)
    else $error("command did not open with select and start bit");
  AST_SER_READY: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r == eel_pkg::S_WAIT && !do_i) |=> !done_o)
    else $error("write finished before ready");
endmodule
`default_nettype wire

// ===== verilog/eel_loader.sv
// Purpose: Board setup loader from a 64 x 16 serial EEPROM
// Assumes: Host port and pins synchronous to CLK_I
// Notes:   Host accesses are ignored while HOST_WAIT_O is high
//
// Notes on behaviour
// - Reset fetches the strap-selected setup values from EEPROM
// - Config at strap*4, base one word above
// - Station address from words 20h to 22h
// - Strap 7: only address read, defaults elsewhere
// - All-high straps give usable fixed defaults
// - 64 whole words, 6-bit word addresses
// - Select 0 reload fills config, base, address
// - Select 0 store writes config and base
// - Control bits are low three, never saved
// - Select 1 reload reads pointer word
// - Select 1 store writes general word
// - Both bits read one while busy
// - Host access blocked until access ends
// - No EEPROM pin: no access, defaults
`include "eel_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module eel_loader #(
  parameter int SK_HALF_CYC = `EEL_SK_HALF_CYC
) (
  input  wire logic        CLK_I,                // System clock
  input  wire logic        SYS_RST_I,            // Sync reset, high
  input  wire logic [2:0]  SLOT_STRAP_PINS_I,    // Slot straps
  input  wire logic        EEPROM_PRESENT_PIN_I, // High when fitted
  input  wire logic        CTRL_WE_I,            // Control write strobe
  input  wire logic [2:0]  CTRL_WDATA_I,         // Control write data
  output logic [2:0]       CTRL_RDATA_O,         // Control readback
  input  wire logic        REG_WE_I,             // Register write strobe
  input  wire logic [2:0]  REG_IDX_I,            // Register index
  input  wire logic [15:0] REG_WDATA_I,          // Register write data
  output logic             HOST_WAIT_O,          // Host access blocked
  output logic [15:0]      CONFIG_O,             // Configuration reg
  output logic [15:0]      BASE_O,               // Base reg
  output logic [15:0]      STATION_ADDR_BYTES_0_1_O, // Address word 0
  output logic [15:0]      STATION_ADDR_BYTES_2_3_O, // Address word 1
  output logic [15:0]      STATION_ADDR_BYTES_4_5_O, // Address word 2
  output logic [15:0]      GP_O,                 // General purpose reg
  output logic [15:0]      PTR_O,                // Pointer reg
  output logic             EE_CS_O,              // EEPROM chip select
  output logic             EE_SK_O,              // EEPROM serial clock
  output logic             EE_DI_O,              // EEPROM data in
  input  wire logic        EE_DO_I               // EEPROM data out
);
  eel_pkg::eel_main_st_t st_r;
  eel_pkg::eel_job_t     job_r;
  logic [2:0]            step_r;
  logic [2:0]            strap_r;
  logic                  present_r;
  logic                  sel_r;
  logic                  busy;
  logic                  host_ok;
  logic                  ser_start;
  logic                  ser_done;
  logic [15:0]           ser_rdata;
  eel_pkg::eel_op_t      ser_op;
  logic [5:0]            ser_addr;
  logic [15:0]           ser_wdata;
  logic                  ewen_ok_r;

  // ****************************************************************
  // Step decoding
  // ****************************************************************
  // Operation of each step; stores interleave write-enable
  function automatic eel_pkg::eel_op_t step_op(input eel_pkg::eel_job_t j,
                                               input logic [2:0] s);
    if (j == eel_pkg::J_LOAD || j == eel_pkg::J_GPRD) begin
      step_op = eel_pkg::OP_READ;
    end else if (s[0]) begin
      step_op = eel_pkg::OP_WRITE;
    end else begin
      step_op = eel_pkg::OP_EWEN;
    end
  endfunction

  // Word address of each step, always six bits
  function automatic logic [5:0] step_addr(input eel_pkg::eel_job_t j,
                                           input logic [2:0] s,
                                           input logic [2:0] strap,
                                           input logic [5:0] ptr);
    if (j == eel_pkg::J_GPRD || j == eel_pkg::J_GPWR) begin
      step_addr = ptr;
    end else if (j == eel_pkg::J_LOAD && s >= 3'h2) begin
      step_addr = `EEL_IA_BASE + {3'h0, s - 3'h2};
    end else if (j == eel_pkg::J_LOAD) begin
      step_addr = {1'b0, strap, 1'b0, s[0]};
    end else begin
      step_addr = {1'b0, strap, 1'b0, s[1]};
    end
  endfunction

  // Final step of each job
  function automatic logic [2:0] last_step(input eel_pkg::eel_job_t j);
    case (j)
      eel_pkg::J_LOAD:  last_step = 3'h4;
      eel_pkg::J_STORE: last_step = 3'h3;
      eel_pkg::J_GPWR:  last_step = 3'h1;
      default:          last_step = 3'h0;
    endcase
  endfunction

  // First load step skips config and base on the fixed strap
  function automatic logic [2:0] first_load(input logic [2:0] strap);
    first_load = strap == `EEL_STRAP_FIXED ? 3'h2 : 3'h0;
  endfunction

  // ****************************************************************
  // Host side
  // ****************************************************************
  assign busy         = st_r != eel_pkg::M_IDLE;
  assign host_ok      = !busy;
  assign HOST_WAIT_O  = busy;
  // Reload and store both read one for any access in flight
  assign CTRL_RDATA_O = {sel_r, busy, busy};
  assign ser_start    = st_r == eel_pkg::M_ISSUE;
  assign ser_op       = step_op(job_r, step_r);
  assign ser_addr     = step_addr(job_r, step_r, strap_r, PTR_O[5:0]);
  assign ser_wdata    = job_r == eel_pkg::J_GPWR ? GP_O :
                        step_r[1] ? BASE_O : CONFIG_O;

  // Select bit lives only here; no EEPROM word holds it
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sel_r <= 1'b0;
    end else if (CTRL_WE_I && host_ok) begin
      sel_r <= CTRL_WDATA_I[`EEL_CTRL_SEL];
    end
  end

  // ****************************************************************
  // Job sequencer
  // ****************************************************************
  // Straps and presence are caught in the first cycle after reset
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st_r      <= eel_pkg::M_STRAP;
      job_r     <= eel_pkg::J_LOAD;
      step_r    <= 3'h0;
      strap_r   <= 3'h0;
      present_r <= 1'b0;
    end else begin
      case (st_r)
        eel_pkg::M_STRAP: begin
          strap_r   <= SLOT_STRAP_PINS_I;
          present_r <= EEPROM_PRESENT_PIN_I;
          job_r     <= eel_pkg::J_LOAD;
          step_r    <= first_load(SLOT_STRAP_PINS_I);
          st_r      <= EEPROM_PRESENT_PIN_I ? eel_pkg::M_ISSUE :
                       eel_pkg::M_IDLE;
        end
        eel_pkg::M_IDLE: begin
          // Reload wins if both bits are written at once
          if (CTRL_WE_I && present_r && CTRL_WDATA_I[`EEL_CTRL_RELOAD]) begin
            job_r  <= CTRL_WDATA_I[`EEL_CTRL_SEL] ? eel_pkg::J_GPRD :
                      eel_pkg::J_LOAD;
            step_r <= CTRL_WDATA_I[`EEL_CTRL_SEL] ? 3'h0 : first_load(strap_r);
            st_r   <= eel_pkg::M_ISSUE;
          end else if (CTRL_WE_I && present_r && CTRL_WDATA_I[`EEL_CTRL_STORE]) begin
            job_r  <= CTRL_WDATA_I[`EEL_CTRL_SEL] ? eel_pkg::J_GPWR :
                      eel_pkg::J_STORE;
            step_r <= 3'h0;
            st_r   <= eel_pkg::M_ISSUE;
          end
        end
        eel_pkg::M_ISSUE: begin
          st_r <= eel_pkg::M_WAIT;
        end
        default: begin
          if (ser_done && step_r == last_step(job_r)) begin
            st_r <= eel_pkg::M_IDLE;
          end else if (ser_done) begin
            step_r <= step_r + 3'h1;
            st_r   <= eel_pkg::M_ISSUE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Setup registers
  // ****************************************************************
  // Fixed strap forces defaults; loads land per step
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      CONFIG_O <= `EEL_CFG_DEFAULT;
      BASE_O   <= `EEL_BASE_DEFAULT;
    end else if (st_r == eel_pkg::M_STRAP &&
                 SLOT_STRAP_PINS_I == `EEL_STRAP_FIXED) begin
      CONFIG_O <= `EEL_CFG_DEFAULT;
      BASE_O   <= `EEL_BASE_DEFAULT;
    end else if (st_r == eel_pkg::M_IDLE && CTRL_WE_I && present_r &&
                 CTRL_WDATA_I[`EEL_CTRL_RELOAD] && !CTRL_WDATA_I[`EEL_CTRL_SEL] &&
                 strap_r == `EEL_STRAP_FIXED) begin
      CONFIG_O <= `EEL_CFG_DEFAULT;
      BASE_O   <= `EEL_BASE_DEFAULT;
    end else if (ser_done && job_r == eel_pkg::J_LOAD && step_r == 3'h0) begin
      CONFIG_O <= ser_rdata;
    end else if (ser_done && job_r == eel_pkg::J_LOAD && step_r == 3'h1) begin
      BASE_O <= ser_rdata;
    end else if (REG_WE_I && host_ok && REG_IDX_I == `EEL_IDX_CFG) begin
      CONFIG_O <= REG_WDATA_I;
    end else if (REG_WE_I && host_ok && REG_IDX_I == `EEL_IDX_BASE) begin
      BASE_O <= REG_WDATA_I;
    end
  end

  // Station address words fill in order from 20h
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      STATION_ADDR_BYTES_0_1_O <= `EEL_IA_DEFAULT;
      STATION_ADDR_BYTES_2_3_O <= `EEL_IA_DEFAULT;
      STATION_ADDR_BYTES_4_5_O <= `EEL_IA_DEFAULT;
    end else if (ser_done && job_r == eel_pkg::J_LOAD && step_r == 3'h2) begin
      STATION_ADDR_BYTES_0_1_O <= ser_rdata;
    end else if (ser_done && job_r == eel_pkg::J_LOAD && step_r == 3'h3) begin
      STATION_ADDR_BYTES_2_3_O <= ser_rdata;
    end else if (ser_done && job_r == eel_pkg::J_LOAD && step_r == 3'h4) begin
      STATION_ADDR_BYTES_4_5_O <= ser_rdata;
    end else if (REG_WE_I && host_ok && REG_IDX_I == `EEL_IDX_IA01) begin
      STATION_ADDR_BYTES_0_1_O <= REG_WDATA_I;
    end else if (REG_WE_I && host_ok && REG_IDX_I == `EEL_IDX_IA23) begin
      STATION_ADDR_BYTES_2_3_O <= REG_WDATA_I;
    end else if (REG_WE_I && host_ok && REG_IDX_I == `EEL_IDX_IA45) begin
      STATION_ADDR_BYTES_4_5_O <= REG_WDATA_I;
    end
  end

  // General purpose word and pointer
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      GP_O  <= 16'h0000;
      PTR_O <= 16'h0000;
    end else begin
      if (ser_done && job_r == eel_pkg::J_GPRD) begin
        GP_O <= ser_rdata;
      end else if (REG_WE_I && host_ok && REG_IDX_I == `EEL_IDX_GP) begin
        GP_O <= REG_WDATA_I;
      end
      if (REG_WE_I && host_ok && REG_IDX_I == `EEL_IDX_PTR) begin
        PTR_O <= REG_WDATA_I;
      end
    end
  end

  // Tracks a write-enable ahead of each write, for checking only
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ewen_ok_r <= 1'b0;
    end else if (ser_done && ser_op == eel_pkg::OP_EWEN) begin
      ewen_ok_r <= 1'b1;
    end else if (ser_done) begin
      ewen_ok_r <= 1'b0;
    end
  end

  eel_serial #(
    .HALF_CYC (SK_HALF_CYC)
  ) u_serial (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .start_i (ser_start),
    .op_i    (ser_op),
    .addr_i  (ser_addr),
    .wdata_i (ser_wdata),
    .done_o  (ser_done),
    .rdata_o (ser_rdata),
    .cs_o    (EE_CS_O),
    .sk_o    (EE_SK_O),
    .di_o    (EE_DI_O),
    .do_i    (EE_DO_I)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_RESET_LOAD: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ($fell(SYS_RST_I) && EEPROM_PRESENT_PIN_I) |=> ser_start)
    else $error("no load after reset");
  AST_CFG_ADDR: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (ser_start && job_r == eel_pkg::J_LOAD && step_r == 3'h0)
      |-> ser_addr == {1'b0, strap_r, 2'b00})
    else $error("config word address wrong");
  AST_IA_ADDR: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (ser_start && job_r == eel_pkg::J_LOAD && step_r == 3'h4) |-> ser_addr == 6'h22)
    else $error("last address word not at 22h");
  AST_FIXED_SKIP: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (ser_start && job_r == eel_pkg::J_LOAD && strap_r == 3'h7) |-> step_r >= 3'h2)
    else $error("fixed strap read config or base");
  AST_GP_ADDR: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (ser_start && job_r == eel_pkg::J_GPRD) |-> ser_addr == PTR_O[5:0])
    else $error("general read not at pointer");
  AST_BOTH_BITS: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    busy |-> CTRL_RDATA_O[1:0] == 2'b11)
    else $error("control bits not both set while busy");
  AST_BLOCKED: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (st_r == eel_pkg::M_WAIT && REG_WE_I && REG_IDX_I == `EEL_IDX_PTR) |=> $stable(PTR_O))
    else $error("host write taken while busy");
  AST_NO_EEPROM: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (st_r != eel_pkg::M_STRAP && !present_r) |-> !EE_CS_O && !ser_start)
    else $error("EEPROM touched with none fitted");
  AST_EWEN_FIRST: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (ser_start && ser_op == eel_pkg::OP_WRITE) |-> ewen_ok_r)
    else $error("write without write-enable");
  AST_STORE_DATA: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (ser_start && job_r == eel_pkg::J_STORE && step_r == 3'h1) |-> ser_wdata == CONFIG_O)
    else $error("store sent wrong config data");
endmodule
`default_nettype wire

// ===== verification/eel_eeprom_model.sv
// Purpose: Behavioural 64 x 16 three-wire serial EEPROM
// Assumes: SK half period of at least two CLK_I cycles
// Notes:   Write enable lapses after each write, stricter than a real part
`timescale 1ns/10ps
`default_nettype none
module eel_eeprom_model (
  input  wire logic       clk_i,      // System clock for edge sampling
  input  wire logic       cs_i,       // Chip select
  input  wire logic       sk_i,       // Serial clock
  input  wire logic       di_i,       // Data into the part
  input  wire logic [7:0] busy_cyc_i, // Write cycle length
  output logic            do_o        // Data out of the part
);
  logic [15:0] mem [0:63];
  logic [24:0] sh = 25'h0;
  logic [5:0]  cnt = 6'h00;
  logic [5:0]  raddr = 6'h00;
  logic        sk_q = 1'b0;
  logic        wen = 1'b0;
  logic        rd = 1'b0;
  logic        rdy = 1'b0;
  logic        shown = 1'b0;
  int          busy = 0;
  int          writes = 0;
  int          bad_writes = 0;
  initial do_o = 1'b0;
  // Undriven line toggles, so a stale bit never passes for data
  always @(posedge clk_i) begin : shifter
    logic [24:0] sh_n;
    sh_n = {sh[23:0], di_i};
    sk_q <= sk_i;
    if (busy > 0) busy <= busy - 1;
    if (!rd) do_o <= ~do_o;
    if (!cs_i) begin
      cnt <= 6'h00;
      rd <= 1'b0;
      if (shown) rdy <= 1'b0;
      shown <= 1'b0;
    end else if (rdy && cnt == 6'h00) begin
      do_o <= (busy == 0);
      if (busy == 0) shown <= 1'b1;
    end else if (sk_i && !sk_q) begin
      sh <= sh_n;
      cnt <= cnt + 6'h01;
      // Header complete after nine clocks
      if (cnt == 6'h08 && sh_n[8:6] == 3'b110) begin
        rd <= 1'b1;
        raddr <= sh_n[5:0];
        do_o <= 1'b0;
      end
      if (cnt == 6'h08 && sh_n[8:4] == 5'b10011) wen <= 1'b1;
      if (rd && cnt >= 6'h09 && cnt <= 6'h18) do_o <= mem[raddr][6'h18 - cnt];
      if (!rd && cnt == 6'h18 && sh_n[24:22] == 3'b101) begin
        if (wen) mem[sh_n[21:16]] <= sh_n[15:0];
        else bad_writes <= bad_writes + 1;
        wen <= 1'b0;
        writes <= writes + 1;
        busy <= int'(busy_cyc_i);
        rdy <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/eel_loader_tb.sv
// Purpose: Self-checking bench for the setup loader
// Assumes: Behavioural EEPROM on the serial pins
// Notes:   Short serial clock through SK_HALF_CYC
`include "eel_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module eel_loader_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  strap = 3'h2;
  logic        present = 1'b1;
  logic        cwe = 1'b0;
  logic [2:0]  cwd = 3'h0;
  logic        rwe = 1'b0;
  logic [2:0]  ridx = 3'h0;
  logic [15:0] rwd = 16'h0000;
  logic [7:0]  busy_cyc = 8'h00;
  logic [2:0]  crd;
  logic        hwait, cs, sk, di, dout;
  logic [15:0] cfg, base, ia01, ia23, ia45, gp, ptr;
  int          mismatches = 0;
  int          checks = 0;
  int          cs_cyc = 0;
  always #5 clk = ~clk;
  // Chip-select activity, for the no-EEPROM case
  always @(posedge clk) cs_cyc <= rst ? 0 : cs_cyc + int'(cs === 1'b1);
  eel_loader #(.SK_HALF_CYC(2)) eel_loader_i (.CLK_I(clk), .SYS_RST_I(rst),
    .SLOT_STRAP_PINS_I(strap), .EEPROM_PRESENT_PIN_I(present), .CTRL_WE_I(cwe),
    .CTRL_WDATA_I(cwd), .CTRL_RDATA_O(crd), .REG_WE_I(rwe), .REG_IDX_I(ridx),
    .REG_WDATA_I(rwd), .HOST_WAIT_O(hwait), .CONFIG_O(cfg), .BASE_O(base),
    .STATION_ADDR_BYTES_0_1_O(ia01), .STATION_ADDR_BYTES_2_3_O(ia23),
    .STATION_ADDR_BYTES_4_5_O(ia45), .GP_O(gp), .PTR_O(ptr), .EE_CS_O(cs),
    .EE_SK_O(sk), .EE_DI_O(di), .EE_DO_I(dout));
  eel_eeprom_model eel_eeprom_model_i (.clk_i(clk), .cs_i(cs), .sk_i(sk), .di_i(di),
    .busy_cyc_i(busy_cyc), .do_o(dout));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Bounded poll of HOST_WAIT_O, up to 5000 cycles
  task automatic wait_idle();
    int n;
    n = 0;
    while (hwait !== 1'b0 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (hwait !== 1'b0) begin
      mismatches++;
      $display("[ERR] host_wait expected 0 seen 1");
      print_verdict();
    end
  endtask
  task automatic wreg(input logic [2:0] idx, input logic [15:0] d);
    @(posedge clk);
    rwe <= 1'b1;
    ridx <= idx;
    rwd <= d;
    @(posedge clk);
    rwe <= 1'b0;
  endtask
  task automatic ctrl(input logic [2:0] v, input logic b);
    @(posedge clk);
    cwe <= 1'b1;
    cwd <= v;
    @(posedge clk);
    cwe <= 1'b0;
    #1;
    chk("ctrl_rdata", {13'h0000, v[2], b, b}, {13'h0000, crd});
    chk("host_wait", {15'h0000, b}, {15'h0000, hwait});
  endtask
  task automatic boot(input logic [2:0] s, input logic p);
    logic [5:0] a;
    logic       ld;
    a = {1'b0, s, 2'b00};
    ld = p && s != `EEL_STRAP_FIXED;
    @(posedge clk);
    rst <= 1'b1;
    strap <= s;
    present <= p;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("boot_ctrl", {14'h0000, p, p}, {14'h0000, crd[1:0]});
    wait_idle();
    chk("config", ld ? eel_eeprom_model_i.mem[a] : `EEL_CFG_DEFAULT, cfg);
    chk("base", ld ? eel_eeprom_model_i.mem[a + 6'h01] : `EEL_BASE_DEFAULT, base);
    chk("ia01", p ? eel_eeprom_model_i.mem[`EEL_IA_BASE] : `EEL_IA_DEFAULT, ia01);
    chk("ia23", p ? eel_eeprom_model_i.mem[6'h21] : `EEL_IA_DEFAULT, ia23);
    chk("ia45", p ? eel_eeprom_model_i.mem[6'h22] : `EEL_IA_DEFAULT, ia45);
    if (!p) chk("cs_cycles", 16'h0000, 16'(cs_cyc));
  endtask
  // General-purpose read and write through the pointer
  task automatic gp_access();
    busy_cyc <= 8'h40;
    wreg(`EEL_IDX_PTR, 16'hffc5);
    ctrl(3'b110, 1'b1);
    wreg(`EEL_IDX_PTR, 16'h0011);
    wait_idle();
    chk("gp_read", eel_eeprom_model_i.mem[6'h05], gp);
    chk("ptr_blocked", 16'hffc5, ptr);
    wreg(`EEL_IDX_GP, 16'hbeef);
    ctrl(3'b101, 1'b1);
    wait_idle();
    chk("gp_word", 16'hbeef, eel_eeprom_model_i.mem[6'h05]);
  endtask
  // Store then reload of the strap-selected words
  task automatic store_load();
    wreg(`EEL_IDX_CFG, 16'h1234);
    wreg(`EEL_IDX_BASE, 16'h8765);
    ctrl(3'b001, 1'b1);
    wait_idle();
    chk("cfg_word", 16'h1234, eel_eeprom_model_i.mem[6'h08]);
    chk("base_word", 16'h8765, eel_eeprom_model_i.mem[6'h09]);
    chk("write_count", 16'h0003, 16'(eel_eeprom_model_i.writes));
    chk("no_ewen", 16'h0000, 16'(eel_eeprom_model_i.bad_writes));
    eel_eeprom_model_i.mem[8] = 16'h0f0f;
    eel_eeprom_model_i.mem[33] = 16'hc0de;
    ctrl(3'b010, 1'b1);
    wait_idle();
    chk("cfg_reload", 16'h0f0f, cfg);
    chk("ia23_reload", 16'hc0de, ia23);
    chk("ctrl_idle", 16'h0000, {13'h0000, crd});
  endtask
  initial begin
    for (int i = 0; i < 64; i++) eel_eeprom_model_i.mem[i] = 16'(i * 16'h0101 ^ 16'h5a3c);
    boot(3'h2, 1'b1);
    gp_access();
    store_load();
    boot(3'h7, 1'b1);
    boot(3'h5, 1'b0);
    ctrl(3'b010, 1'b0);
    chk("cs_idle", 16'h0000, 16'(cs_cyc));
    print_verdict();
  end
endmodule
`default_nettype wire
